// [fault_trip_output_control.sv]
// fault trip and general output conditioning with apb registers
`timescale 1ns/1ps
module fault_trip_output_control
    import fto_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF // clocks per 10 ms
) (
    input wire logic ref_clk_i, // 25 MHz system clock
    input wire logic rst_i, // async reset, active high
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb direction
    input wire logic [7:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error, unmapped address
    input wire logic uv_trip_i, // undervoltage trip active
    input wire logic other_trip_i, // other fault trip active
    input wire logic restart_fail_i, // auto restart failed
    input wire logic [31:0] func_cond_i, // condition per function code
    input wire logic exp_present_i, // expansion module fitted (pin)
    output logic first_relay_o, // relay 1 coil
    output logic second_relay_o, // relay 2 coil
    output logic multi_function_terminal_o, // terminal output
    output logic [2:0] exp_out_o, // expansion outputs
    output logic irq_o // level interrupt
);
    typedef struct packed {
        logic [2:0] mask;
        logic [NUM_CH-1:0] pol;
        logic [NUM_CH-1:0][SEL_W-1:0] sel;
        logic [DLY_W-1:0] ton;
        logic [DLY_W-1:0] toff;
        logic [DLY_W-1:0] don;
        logic [DLY_W-1:0] doff;
        logic [2:0] sts;
        logic [2:0] msk;
        logic [2:0] trip_prev;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [1:0] exp_sync;
        logic [NUM_CH-1:0] pin;
        logic [31:0] rdata;
    } ctl_t;

    ctl_t q;
    ctl_t d;
    logic [2:0] trips;
    logic trip_act;
    logic exp;
    logic wr;
    logic [2:0] clr;
    logic [NUM_CH-1:0] trip_mode;
    logic [NUM_CH-1:0] cond;
    logic [NUM_CH-1:0] tout;
    logic [NUM_CH-1:0] ch_ena;
    logic [NUM_CH-1:0] pin_raw;

    // pack three select slots into one register word
    function automatic logic [31:0] sel_word(
        input logic [NUM_CH-1:0][SEL_W-1:0] s,
        input int base
    );
        logic [31:0] w;
        w = '0;
        for (int k = 0; k < NUM_BASE; k++) begin
            w[k*SEL_STRIDE +: SEL_W] = s[base+k];
        end
        return w;
    endfunction

    // trip classes, gated by the mask; sources share our clock
    assign trips = {restart_fail_i, other_trip_i, uv_trip_i};
    assign trip_act = |(trips & q.mask);
    assign exp = q.exp_sync[1];
    assign ch_ena = {{(NUM_CH-NUM_BASE){exp}}, {NUM_BASE{1'b1}}};
    assign wr = psel_i && penable_i && pwrite_i;
    assign clr = (wr && paddr_i == IRQ_STS_ADDR) ? pwdata_i[2:0] : 3'h0;
    // raw polarity before the expansion gate
    assign pin_raw = tout ^ q.pol;

    // per-channel condition select and delay qualifier
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        // trip code picks the trip condition
        assign trip_mode[c] = q.sel[c] == TRIP_CODE;
        assign cond[c] = ch_ena[c] &&
            (trip_mode[c] ? trip_act : func_cond_i[q.sel[c]]);
        // trip mode swaps in the trip delays
        output_delay_timer u_output_delay_timer (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .tick_i(q.tick),
            .cond_i(cond[c]),
            .on_dly_i(trip_mode[c] ? q.ton : q.don),
            .off_dly_i(trip_mode[c] ? q.toff : q.doff),
            .out_o(tout[c])
        );
    end

    // next-state logic: divider, sync, registers, status, pins
    always_comb begin
        d = q;
        d.exp_sync = {q.exp_sync[0], exp_present_i};
        d.tick = 1'b0;
        if (q.div == DIV_W'(TICK_CYCLES - 1)) begin
            d.div = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + 1'b1;
        end
        // read data latched in the setup phase so prdata is a flop
        if (psel_i && !penable_i) begin
            d.rdata = '0;
            case (paddr_i)
                TRIP_MASK_ADDR: d.rdata[2:0] = q.mask;
                POL_ADDR: d.rdata[NUM_CH-1:0] = q.pol;
                SEL_MAIN_ADDR: d.rdata = sel_word(q.sel, 0);
                SEL_EXP_ADDR: d.rdata = sel_word(q.sel, NUM_BASE);
                TRIP_ON_ADDR: d.rdata[DLY_W-1:0] = q.ton;
                TRIP_OFF_ADDR: d.rdata[DLY_W-1:0] = q.toff;
                DO_ON_ADDR: d.rdata[DLY_W-1:0] = q.don;
                DO_OFF_ADDR: d.rdata[DLY_W-1:0] = q.doff;
                OUT_STATE_ADDR: begin
                    d.rdata[NUM_CH-1:0] = q.pin;
                    d.rdata[OUT_TRIP_BIT] = trip_act;
                    d.rdata[OUT_EXP_BIT] = exp;
                end
                IRQ_STS_ADDR: d.rdata[2:0] = q.sts;
                IRQ_MSK_ADDR: d.rdata[2:0] = q.msk;
                default: d.rdata = '0;
            endcase
        end
        // register writes take effect in the access phase
        if (wr) begin
            case (paddr_i)
                TRIP_MASK_ADDR: d.mask = pwdata_i[2:0];
                POL_ADDR: d.pol = pwdata_i[NUM_CH-1:0];
                SEL_MAIN_ADDR: begin
                    for (int k = 0; k < NUM_BASE; k++) begin
                        d.sel[k] = pwdata_i[k*SEL_STRIDE +: SEL_W];
                    end
                end
                SEL_EXP_ADDR: begin
                    for (int k = 0; k < NUM_BASE; k++) begin
                        d.sel[NUM_BASE+k] = pwdata_i[k*SEL_STRIDE +: SEL_W];
                    end
                end
                TRIP_ON_ADDR: d.ton = pwdata_i[DLY_W-1:0];
                TRIP_OFF_ADDR: d.toff = pwdata_i[DLY_W-1:0];
                DO_ON_ADDR: d.don = pwdata_i[DLY_W-1:0];
                DO_OFF_ADDR: d.doff = pwdata_i[DLY_W-1:0];
                IRQ_MSK_ADDR: d.msk = pwdata_i[2:0];
                default: ;
            endcase
        end
        // expansion polarity bits exist only with the module
        if (!exp) begin
            d.pol[NUM_CH-1:NUM_BASE] = '0;
        end
        // trip class onsets are sticky; a new onset beats the clear
        d.trip_prev = trips;
        d.sts = (q.sts & ~clr) | (trips & ~q.trip_prev);
        // polarity applied per bit, lsb relay 1
        d.pin = pin_raw & ch_ena;
    end

    // state register with documented reset values
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.mask <= TRIP_MASK_RST;
            q.pol <= POL_RST;
            q.sel[CH_FIRST_RELAY] <= SEL_FIRST_RELAY_RST;
            q.sel[CH_MFT] <= SEL_MFT_RST;
            q.sel[CH_RELAY2] <= SEL_RELAY2_RST;
            for (int k = NUM_BASE; k < NUM_CH; k++) begin
                q.sel[k] <= SEL_EXP_RST;
            end
            q.ton <= DLY_RST;
            q.toff <= DLY_RST;
            q.don <= DLY_RST;
            q.doff <= DLY_RST;
            q.msk <= IRQ_MSK_RST;
        end else begin
            q <= d;
        end
    end

    // outputs: pins and read data from flops, handshake combinational
    assign first_relay_o = q.pin[CH_FIRST_RELAY];
    assign multi_function_terminal_o = q.pin[CH_MFT];
    assign second_relay_o = q.pin[CH_RELAY2];
    assign exp_out_o = q.pin[NUM_CH-1:NUM_BASE];
    assign prdata_o = q.rdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok(paddr_i);
    assign irq_o = |(q.sts & q.msk);

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // relay 1 set up as a plain trip output with no on delay
    logic r1_trip_cfg;
    assign r1_trip_cfg = q.sel[CH_FIRST_RELAY] == TRIP_CODE &&
        q.ton == DLY_RST && !q.pol[CH_FIRST_RELAY];

    property p_uv_trip;
        (q.mask == 3'h1 && uv_trip_i && r1_trip_cfg)[*3]
            |-> first_relay_o;
    endproperty
    a_uv_trip: assert property (p_uv_trip)
        else $error("undervoltage trip did not reach relay 1");

    property p_other_trip;
        (q.mask == 3'h2 && other_trip_i && r1_trip_cfg)[*3]
            |-> first_relay_o;
    endproperty
    a_other_trip: assert property (p_other_trip)
        else $error("fault trip did not reach relay 1");

    property p_rfail_trip;
        (q.mask == 3'h4 && restart_fail_i && r1_trip_cfg)[*3]
            |-> first_relay_o;
    endproperty
    a_rfail_trip: assert property (p_rfail_trip)
        else $error("restart failure did not reach relay 1");

    property p_mask_rst;
        $fell(rst_i) |-> q.mask == TRIP_MASK_RST && q.pol == POL_RST;
    endproperty
    a_mask_rst: assert property (p_mask_rst)
        else $error("mask or polarity wrong after reset");

    property p_no_trip;
        (!trip_act && q.sel[CH_FIRST_RELAY] == TRIP_CODE &&
            q.toff == DLY_RST && !q.pol[CH_FIRST_RELAY])[*3]
            |-> !first_relay_o;
    endproperty
    a_no_trip: assert property (p_no_trip)
        else $error("relay 1 on without an enabled trip");

    property p_gen_dly;
        (q.sel[CH_RELAY2] != TRIP_CODE && q.don == DLY_RST &&
            func_cond_i[q.sel[CH_RELAY2]] && !q.pol[CH_RELAY2])[*3]
            |-> second_relay_o;
    endproperty
    a_gen_dly: assert property (p_gen_dly)
        else $error("relay 2 ignored the general on delay");

    property p_pol_r1;
        1'b1 |=> first_relay_o ==
            ($past(tout[CH_FIRST_RELAY]) ^ $past(q.pol[CH_FIRST_RELAY]));
    endproperty
    a_pol_r1: assert property (p_pol_r1)
        else $error("relay 1 polarity wrong");

    property p_pol_mft;
        1'b1 |=> multi_function_terminal_o ==
            ($past(tout[CH_MFT]) ^ $past(q.pol[CH_MFT]));
    endproperty
    a_pol_mft: assert property (p_pol_mft)
        else $error("terminal polarity bit order wrong");

    property p_exp_off;
        !exp |=> exp_out_o == 3'h0 && q.pol[NUM_CH-1:NUM_BASE] == 3'h0;
    endproperty
    a_exp_off: assert property (p_exp_off)
        else $error("expansion outputs active without module");

    // a terminal on a general function follows its condition at zero delay
    property p_mft_gen;
        (q.sel[CH_MFT] != TRIP_CODE && q.don == DLY_RST &&
            func_cond_i[q.sel[CH_MFT]] && !q.pol[CH_MFT])[*3]
            |-> multi_function_terminal_o;
    endproperty
    a_mft_gen: assert property (p_mft_gen)
        else $error("terminal ignored the general on delay");

    property p_gen_off;
        (q.sel[CH_RELAY2] != TRIP_CODE && q.doff == DLY_RST &&
            !func_cond_i[q.sel[CH_RELAY2]] && !q.pol[CH_RELAY2])[*3]
            |-> !second_relay_o;
    endproperty
    a_gen_off: assert property (p_gen_off)
        else $error("relay 2 ignored the general off delay");

    property p_pol_r2;
        1'b1 |=> second_relay_o ==
            ($past(tout[CH_RELAY2]) ^ $past(q.pol[CH_RELAY2]));
    endproperty
    a_pol_r2: assert property (p_pol_r2)
        else $error("relay 2 polarity wrong");

    // a bare pin reaches the gate only through both sync flops
    property p_exp_sync;
        ((!exp_present_i)[*3] |-> !exp) and
            ((exp_present_i)[*3] |-> exp);
    endproperty
    a_exp_sync: assert property (p_exp_sync)
        else $error("expansion presence not synchronised");

    property p_pol_exp;
        exp |=> {exp_out_o, 3'h0} == ($past(pin_raw) & 6'h38);
    endproperty
    a_pol_exp: assert property (p_pol_exp)
        else $error("expansion polarity wrong");

    // the step pulse coincides with the divider wrapping to zero
    property p_tick;
        q.tick |-> q.div == '0;
    endproperty
    a_tick: assert property (p_tick)
        else $error("time base step out of phase");

    // a mask write lands on the access edge, wider bits dropped
    property p_mask_wr;
        wr && paddr_i == TRIP_MASK_ADDR |=>
            {29'h0, q.mask} == ($past(pwdata_i) & 32'h7);
    endproperty
    a_mask_wr: assert property (p_mask_wr)
        else $error("trip mask write lost");

    c_trip_relay: cover property (trip_act ##[1:4] $rose(first_relay_o));
    c_irq: cover property ($rose(irq_o));
    c_exp_out: cover property (exp && exp_out_o != 3'h0);
    c_apb_err: cover property (pslverr_o);
    c_gen_relay: cover property ($rose(second_relay_o));
endmodule

// [fto_pkg.sv]
// shared constants for the fault trip output conditioning block
package fto_pkg;
    // register byte addresses
    localparam logic [7:0] TRIP_MASK_ADDR = 8'h00;
    localparam logic [7:0] POL_ADDR = 8'h04;
    localparam logic [7:0] SEL_MAIN_ADDR = 8'h08;
    localparam logic [7:0] SEL_EXP_ADDR = 8'h0c;
    localparam logic [7:0] TRIP_ON_ADDR = 8'h10;
    localparam logic [7:0] TRIP_OFF_ADDR = 8'h14;
    localparam logic [7:0] DO_ON_ADDR = 8'h18;
    localparam logic [7:0] DO_OFF_ADDR = 8'h1c;
    localparam logic [7:0] OUT_STATE_ADDR = 8'h20;
    localparam logic [7:0] IRQ_STS_ADDR = 8'h24;
    localparam logic [7:0] IRQ_MSK_ADDR = 8'h28;
    // trip class bits, shared by mask, status and interrupt mask
    localparam int UV_BIT = 0;
    localparam int OTHER_BIT = 1;
    localparam int RFAIL_BIT = 2;
    localparam logic [2:0] TRIP_MASK_RST = 3'h2;
    localparam logic [2:0] IRQ_MSK_RST = 3'h0;
    // output channels: polarity bit order and select slots
    localparam int CH_FIRST_RELAY = 0;
    localparam int CH_MFT = 1;
    localparam int CH_RELAY2 = 2;
    localparam int NUM_BASE = 3;
    localparam int NUM_CH = 6;
    localparam logic [NUM_CH-1:0] POL_RST = 6'h00;
    // function select fields, one byte slot per channel
    localparam int SEL_W = 5;
    localparam int SEL_STRIDE = 8;
    localparam logic [SEL_W-1:0] TRIP_CODE = 5'h1c;
    localparam logic [SEL_W-1:0] SEL_FIRST_RELAY_RST = 5'h1c;
    localparam logic [SEL_W-1:0] SEL_MFT_RST = 5'h01;
    localparam logic [SEL_W-1:0] SEL_RELAY2_RST = 5'h0e;
    localparam logic [SEL_W-1:0] SEL_EXP_RST = 5'h00;
    // output state register fields
    localparam int OUT_TRIP_BIT = 8;
    localparam int OUT_EXP_BIT = 9;
    // delays in 10 ms steps
    localparam int DLY_W = 16;
    localparam logic [DLY_W-1:0] DLY_RST = 16'h0000;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
    localparam int DIV_W = 18;

    // true for every mapped register address
    function automatic logic addr_ok(input logic [7:0] a);
        return a <= IRQ_MSK_ADDR && a[1:0] == 2'b00;
    endfunction
endpackage

// [output_delay_timer.sv]
// on/off delay qualifier for one output channel
`timescale 1ns/1ps
module output_delay_timer
    import fto_pkg::*;
(
    input wire logic ref_clk_i, // system clock
    input wire logic rst_i, // async reset, active high
    input wire logic tick_i, // one-cycle 10 ms step
    input wire logic cond_i, // raw output condition
    input wire logic [DLY_W-1:0] on_dly_i, // on delay, steps
    input wire logic [DLY_W-1:0] off_dly_i, // off delay, steps
    output logic out_o // qualified condition
);
    typedef struct packed {
        logic out;
        logic [DLY_W-1:0] cnt;
    } tmr_t;

    tmr_t q;
    tmr_t d;

    // count steps while the condition differs from the output
    always_comb begin
        d = q;
        if (cond_i == q.out) begin
            d.cnt = '0;
        end else if (cond_i && q.cnt >= on_dly_i) begin
            d.out = 1'b1;
            d.cnt = '0;
        end else if (!cond_i && q.cnt >= off_dly_i) begin
            d.out = 1'b0;
            d.cnt = '0;
        end else if (tick_i && q.cnt != '1) begin
            // saturate so a huge delay never wraps to zero
            d.cnt = q.cnt + 1'b1;
        end
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out_o = q.out;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_on_dly;
        $rose(q.out) |-> $past(cond_i) && $past(q.cnt) >= $past(on_dly_i);
    endproperty
    a_on_dly: assert property (p_on_dly)
        else $error("output rose before on delay");

    property p_off_dly;
        $fell(q.out) |-> !$past(cond_i) && $past(q.cnt) >= $past(off_dly_i);
    endproperty
    a_off_dly: assert property (p_off_dly)
        else $error("output fell before off delay");

    property p_restart;
        (cond_i == q.out) |=> q.cnt == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("delay count not restarted");
endmodule

// [output_load_model.sv]
// relay coil and terminal load model with contact pickup lag
`timescale 1ns/1ps
module output_load_model #(
    parameter int PICKUP = 2 // cycles until a contact follows its coil
) (
    input wire logic ref_clk_i, // system clock
    input wire logic [5:0] coil_i, // relay coils and terminal loads
    output logic [5:0] contact_o // contact state seen by the plant
);
    logic [5:0] pipe_q [PICKUP];

    // mechanical lag: a contact repeats its coil PICKUP cycles later, even a one-cycle pulse
    always_ff @(posedge ref_clk_i) begin
        pipe_q[0] <= coil_i;
        for (int i = 1; i < PICKUP; i++) begin
            pipe_q[i] <= pipe_q[i-1];
        end
    end
    assign contact_o = pipe_q[PICKUP-1];
endmodule

// [test_fault_trip_output_control.sv]
// self-checking bench for the fault trip output block
`timescale 1ns/1ps
module test_fault_trip_output_control;
    import fto_pkg::*;
    localparam int TC = 4; // short delay step keeps the run brief
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [2:0] trip_v = 3'h0;
    logic [31:0] cond_v = 32'h0;
    logic exp_v = 1'b0;
    wire [5:0] pins;
    logic [5:0] contacts;
    int num_errors = 0;
    int num_checks = 0;

    fault_trip_output_control #(.TICK_CYCLES(TC))
        u_fault_trip_output_control (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .uv_trip_i(trip_v[0]),
        .other_trip_i(trip_v[1]), .restart_fail_i(trip_v[2]),
        .func_cond_i(cond_v), .exp_present_i(exp_v),
        .first_relay_o(pins[0]), .second_relay_o(pins[2]),
        .multi_function_terminal_o(pins[1]), .exp_out_o(pins[5:3]),
        .irq_o(irq));

    output_load_model u_output_load_model (
        .ref_clk_i(ref_clk_i), .coil_i(pins), .contact_o(contacts));

    // 25 MHz system clock
    always #20 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
            input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic hang(input string what);
        num_errors++;
        $display("unexpected at %0t: %s timed out", $time, what);
        wrap_up;
    endtask

    // one apb transfer; an idle edge follows so the next setup is clean
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk_i);
            if (pready === 1'b1) break;
        end
        if (n == 20) hang("apb ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
            input logic err_exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, "read data");
        chk({31'h0, e}, {31'h0, err_exp}, "slave error");
    endtask

    // edges from the stimulus edge until pin c reaches v, within n steps
    task automatic dly(input int c, input logic v, input int n);
        int lo;
        int hi;
        int k;
        lo = (n == 0) ? 2 : (n - 1) * TC + 1;
        hi = (n == 0) ? 2 : n * TC + 3;
        for (k = 0; k <= hi; k++) begin
            @(negedge ref_clk_i);
            if (pins[c] === v) break;
        end
        if (k > hi) hang("output delay");
        chk({31'h0, k >= lo}, 32'h1, "output too early");
        @(posedge ref_clk_i);
    endtask

    task automatic t_reset;
        rd(TRIP_MASK_ADDR, 32'h2, 1'b0);
        rd(POL_ADDR, 32'h0, 1'b0);
        rd(SEL_MAIN_ADDR, 32'h000e011c, 1'b0);
        rd(TRIP_ON_ADDR, 32'h0, 1'b0);
        rd(DO_OFF_ADDR, 32'h0, 1'b0);
        rd(8'h2c, 32'h0, 1'b1);
        wr(TRIP_MASK_ADDR, 32'hff);
        rd(TRIP_MASK_ADDR, 32'h7, 1'b0);
    endtask

    // each class alone in the mask, each trip alone on the inputs
    task automatic t_classes;
        wr(SEL_MAIN_ADDR, 32'h001c011c);
        for (int m = 0; m < 3; m++) begin
            wr(TRIP_MASK_ADDR, 32'h1 << m);
            for (int t = 0; t < 3; t++) begin
                trip_v <= 3'h1 << t;
                repeat (3) @(posedge ref_clk_i);
                chk({29'h0, pins[2:0]}, (m == t) ? 32'h5 : 32'h0,
                    "trip outputs");
                trip_v <= 3'h0;
                repeat (3) @(posedge ref_clk_i);
            end
        end
    endtask

    task automatic t_irq;
        wr(IRQ_STS_ADDR, 32'h7);
        wr(TRIP_MASK_ADDR, 32'h0);
        trip_v <= 3'h4;
        repeat (3) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h0, "irq while masked");
        chk({31'h0, pins[0]}, 32'h0, "relay with class off");
        rd(IRQ_STS_ADDR, 32'h4, 1'b0);
        wr(IRQ_MSK_ADDR, 32'h4);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(IRQ_STS_ADDR, 32'h4);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        rd(IRQ_STS_ADDR, 32'h0, 1'b0);
        trip_v <= 3'h0;
        @(posedge ref_clk_i);
    endtask

    // long general delays must not slow the trip relay
    task automatic t_delays;
        wr(TRIP_MASK_ADDR, 32'h2);
        wr(SEL_MAIN_ADDR, 32'h000e011c);
        wr(TRIP_ON_ADDR, 32'h2);
        wr(TRIP_OFF_ADDR, 32'h3);
        wr(DO_ON_ADDR, 32'h9);
        wr(DO_OFF_ADDR, 32'h9);
        trip_v <= 3'h2;
        @(posedge ref_clk_i);
        trip_v <= 3'h0;
        repeat (12) @(posedge ref_clk_i);
        chk({31'h0, pins[0]}, 32'h0, "glitch reached relay");
        trip_v <= 3'h2;
        dly(0, 1'b1, 2);
        trip_v <= 3'h0;
        dly(0, 1'b0, 3);
    endtask

    task automatic t_general;
        wr(DO_ON_ADDR, 32'h2);
        wr(DO_OFF_ADDR, 32'h1);
        cond_v <= 32'h4002;
        dly(1, 1'b1, 2);
        chk({31'h0, pins[2]}, 32'h1, "relay 2 on delay");
        cond_v <= 32'h0;
        dly(1, 1'b0, 1);
        // zero on delay: both general outputs follow in two cycles
        wr(DO_ON_ADDR, 32'h0);
        cond_v <= 32'h4002;
        dly(2, 1'b1, 0);
        chk({31'h0, pins[1]}, 32'h1, "terminal zero delay");
        cond_v <= 32'h0;
        dly(2, 1'b0, 1);
    endtask

    // polarity order, then the expansion bits once the module is fitted
    task automatic t_polarity;
        wr(POL_ADDR, 32'h01);
        repeat (3) @(posedge ref_clk_i);
        chk({26'h0, pins}, 32'h01, "relay 1 inverted");
        wr(POL_ADDR, 32'h3f);
        rd(POL_ADDR, 32'h07, 1'b0);
        repeat (3) @(posedge ref_clk_i);
        chk({26'h0, pins}, 32'h07, "base outputs inverted");
        exp_v <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        wr(POL_ADDR, 32'h3f);
        rd(POL_ADDR, 32'h3f, 1'b0);
        repeat (3) @(posedge ref_clk_i);
        chk({26'h0, pins}, 32'h3f, "expansion inverted");
        chk({26'h0, contacts}, 32'h3f, "load contacts");
        // an idle expansion trip output keeps its inverted level
        wr(SEL_EXP_ADDR, 32'h0000001c);
        rd(SEL_EXP_ADDR, 32'h0000001c, 1'b0);
        rd(OUT_STATE_ADDR, 32'h0000023f, 1'b0);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // reset, then each scenario in turn
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset;
        t_classes;
        t_irq;
        t_delays;
        t_general;
        t_polarity;
        wrap_up;
    end
endmodule
